// ### src/ufi_core.v
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "ufi_defs.vh"
module ufi_core #(
  parameter SUSPEND_CYC  = `UFI_SUSPEND_CYC,
  parameter BUSRESET_CYC = `UFI_BUSRESET_CYC,
  parameter NEP          = 5,
  parameter FIFO_BYTES   = `UFI_FIFO_BYTES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        line_idle,
  input  wire        line_se0,
  input  wire [2:0]  ev_ep,
  input  wire        ev_rx_good,
  input  wire        ev_tx_ack,
  input  wire        ev_tx_sent,
  input  wire        ev_halt,
  input  wire        ev_overflow,
  input  wire        ev_starve,
  input  wire        ev_setup_abort,
  input  wire        ev_data_last_clr,
  input  wire        ev_iso_ovr,
  input  wire        ev_sof,
  input  wire        in_token,
  input  wire [2:0]  in_token_ep,
  output reg         in_send,
  output reg         in_nak,
  output reg         in_data_toggle,
  output reg         func_irq,
  output reg         sof_irq
);
  localparam NE = NEP;
  reg [7:0]  stat1_reg;
  reg [7:0]  stat2_reg;
  reg [7:0]  ien1_reg;
  reg [7:0]  ien2_reg;
  reg [1:0]  ica_reg;
  reg [2:0]  epsel_reg;
  reg [7:0]  max_packet_size_reg [0:NE-1];
  reg [NE-1:0] auto_reg;
  reg [NE-1:0] fbt_reg;
  reg [NE-1:0] tog_reg;
  reg [NE-1:0] under_reg;
  reg        suspended_reg;
  reg        line_idle_d_reg;
  reg        aw_hold_reg;
  reg        w_hold_reg;
  reg [7:0]  awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  wire       suspend_hit;
  wire       busreset_hit;
  wire       usb_rst = busreset_hit;
  wire [NE-1:0] loaded;
  wire [NE-1:0] occupied;
  wire [NE-1:0] dual;
  wire [7:0]    rd_byte [0:NE-1];

  // one-hot of an endpoint number
  function [NE-1:0] ep_hot;
    input [2:0] ep;
    begin
      ep_hot = (ep < NE) ? ({{(NE-1){1'b0}}, 1'b1} << ep) : {NE{1'b0}};
    end
  endfunction

  // packet size seen by a fifo: ep0 never double buffers, and an oversize
  // value must not wrap into the dual range when cut to five bits
  function [4:0] fifo_max_packet_size;
    input [7:0] mp;
    input       is_ep0;
    begin
      if (is_ep0 || mp > FIFO_BYTES)
        fifo_max_packet_size = 5'h1F;
      else
        fifo_max_packet_size = mp[4:0];
    end
  endfunction

  ufi_idle_timer #(.LIMIT(SUSPEND_CYC)) u_susp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cond    (line_idle & ~suspended_reg),
    .hit     (suspend_hit)
  );
  ufi_idle_timer #(.LIMIT(BUSRESET_CYC)) u_brst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cond    (line_se0),
    .hit     (busreset_hit)
  );

  // write channel: either order, response after both
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
  wire       aw_now = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
  wire       w_now  = w_hold_reg | (s_axi_wvalid & s_axi_wready);
  wire       wr_go  = aw_now & w_now;
  wire [7:0]  wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]  ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;
  wire       wr_b0 = wr_go & ws[0];
  wire [NE-1:0] sel = ep_hot(epsel_reg);
  wire       wr_fifo = wr_b0 && wa == `UFI_ADDR_IN_FIFO;
  wire       wr_inctl = wr_b0 && wa == `UFI_ADDR_IN_CTL;
  // writes while loaded are dropped so the armed packet stays intact
  wire [NE-1:0] fifo_we = (wr_fifo ? sel : {NE{1'b0}}) & ~loaded;
  wire [NE-1:0] arm_set = (wr_inctl && wd[`UFI_IC_LOADED_BIT]) ? sel : {NE{1'b0}};
  wire [NE-1:0] flush_set = (wr_inctl && wd[`UFI_IC_FLUSH_BIT]) ? sel : {NE{1'b0}};
  wire [NE-1:0] ev_hot = ep_hot(ev_ep);
  wire [NE-1:0] ack_hot = ev_tx_ack ? ev_hot : {NE{1'b0}};
  wire [NE-1:0] abort_hot = {{(NE-1){1'b0}}, ev_setup_abort};
  wire [NE-1:0] tok_hot = in_token ? ep_hot(in_token_ep) : {NE{1'b0}};
  // feedback endpoints send on every token, ack or not
  wire [NE-1:0] sent_hot = ack_hot | ((ev_tx_sent ? ev_hot : {NE{1'b0}}) & fbt_reg);

  genvar g;
  generate
    for (g = 0; g < NE; g = g + 1) begin : g_ep
      ufi_in_fifo #(.DEPTH(FIFO_BYTES), .AW(4)) u_fifo (
        .aclk               (aclk),
        .aresetn            (aresetn & ~usb_rst),
        .wr_en              (fifo_we[g]),
        .wr_data            (wd[7:0]),
        .max_packet_size    (fifo_max_packet_size(max_packet_size_reg[g], g == 0)),
        .auto_arm           (auto_reg[g] & (g != 0)),
        .arm_set            (arm_set[g]),
        .pkt_done           (sent_hot[g]),
        .flush              (flush_set[g]),
        .abort_clr          (abort_hot[g]),
        .rd_en              (tok_hot[g]),
        .rd_data            (rd_byte[g]),
        .packet_loaded_flag (loaded[g]),
        .occupied           (occupied[g]),
        .dual_mode          (dual[g])
      );
    end
  endgenerate

  // event status bits: set wins over software clear
  wire [7:0] set1;
  wire [7:0] set2;
  wire       ep0_ev = ev_hot[0] & (ev_rx_good | ev_tx_ack | ev_halt | ev_setup_abort | ev_data_last_clr);
  assign set1[0] = ep0_ev;
  assign set1[4:1] = ev_hot[4:1] & {4{ev_rx_good | ev_halt | ev_overflow}};
  assign set1[7:5] = 3'b000;
  assign set2[3:0] = ev_hot[4:1] & {4{ev_tx_ack | ev_starve}};
  assign set2[`UFI_S2_OVR_BIT] = ev_iso_ovr;
  assign set2[`UFI_S2_RST_BIT] = busreset_hit;
  assign set2[`UFI_S2_RES_BIT] = suspended_reg & line_idle_d_reg & ~line_idle;
  assign set2[`UFI_S2_SUS_BIT] = suspend_hit;
  wire [7:0] clr1 = (wr_b0 && wa == `UFI_ADDR_STAT1) ? wd[7:0] : 8'h00;
  wire [7:0] clr2 = (wr_b0 && wa == `UFI_ADDR_STAT2) ? wd[7:0] : 8'h00;
  // reset and resume bits are always enabled
  wire [7:0] en2 = ien2_reg | 8'h60;
  wire any_func = |(stat1_reg & ien1_reg) | |(stat2_reg & en2);
  integer i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      stat1_reg <= 8'h00;
      stat2_reg <= 8'h00;
      line_idle_d_reg <= 1'b0;
      suspended_reg <= 1'b0;
      func_irq <= 1'b0;
      sof_irq <= 1'b0;
      ica_reg <= 2'b00;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      line_idle_d_reg <= line_idle;
      // reset event keeps only its own flag; other status returns to default
      if (usb_rst) begin
        stat1_reg <= 8'h00;
        stat2_reg <= (stat2_reg & ~clr2 & 8'h20) | set2;
        suspended_reg <= 1'b0;
      end else begin
        stat1_reg <= (stat1_reg & ~clr1) | set1;
        stat2_reg <= (stat2_reg & ~clr2) | set2;
        if (suspend_hit)
          suspended_reg <= 1'b1;
        else if (set2[`UFI_S2_RES_BIT])
          suspended_reg <= 1'b0;
      end
      func_irq <= ica_reg[`UFI_ICA_FUNC_BIT] & any_func;
      sof_irq <= ica_reg[`UFI_ICA_SOF_BIT] & ev_sof;
      if (wr_b0 && wa == `UFI_ADDR_IRQ_CTL_A)
        ica_reg <= wd[1:0];
      if (s_axi_awvalid && s_axi_awready && !wr_go) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa > `UFI_ADDR_EVENT || wa[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // usb-side registers, also returned to defaults by bus reset
  always @(posedge aclk) begin
    if (!aresetn || usb_rst) begin
      ien1_reg <= 8'hFF;
      ien2_reg <= 8'hFF;
      epsel_reg <= 3'b000;
      auto_reg <= {NE{1'b0}};
      fbt_reg <= {NE{1'b0}};
      tog_reg <= {NE{1'b0}};
      under_reg <= {NE{1'b0}};
      for (i = 0; i < NE; i = i + 1)
        max_packet_size_reg[i] <= 8'h08;
    end else begin
      if (wr_b0 && wa == `UFI_ADDR_IEN1)
        ien1_reg <= wd[7:0];
      if (wr_b0 && wa == `UFI_ADDR_IEN2)
        ien2_reg <= wd[7:0];
      if (wr_b0 && wa == `UFI_ADDR_EP_INDEX)
        epsel_reg <= wd[2:0];
      for (i = 0; i < NE; i = i + 1) begin
        if (wr_b0 && wa == `UFI_ADDR_MAX_PACKET_SIZE && sel[i])
          max_packet_size_reg[i] <= wd[7:0];
        if (wr_inctl && sel[i]) begin
          auto_reg[i] <= wd[`UFI_IC_AUTO_BIT];
          fbt_reg[i] <= wd[`UFI_IC_FBT_BIT];
        end
        if (sent_hot[i])
          tog_reg[i] <= ~tog_reg[i];
        if (ev_starve && ev_hot[i])
          under_reg[i] <= 1'b1;
        else if (wr_inctl && sel[i] && wd[`UFI_IC_UNDER_BIT])
          under_reg[i] <= 1'b0;
      end
    end
  end

  // token answer: feedback endpoints always send, others only when armed
  wire [2:0] tep = (in_token_ep < NE) ? in_token_ep : 3'b000;
  always @(posedge aclk) begin
    if (!aresetn) begin
      in_send <= 1'b0;
      in_nak <= 1'b0;
      in_data_toggle <= 1'b0;
    end else begin
      in_send <= in_token & (fbt_reg[tep] | occupied[tep]);
      in_nak <= in_token & ~fbt_reg[tep] & ~occupied[tep];
      in_data_toggle <= tog_reg[tep];
    end
  end

  // read channel answers one cycle after the address is taken
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr == `UFI_ADDR_STAT1)
        s_axi_rdata <= {24'h00_0000, stat1_reg};
      else if (s_axi_araddr == `UFI_ADDR_STAT2)
        s_axi_rdata <= {24'h00_0000, stat2_reg};
      else if (s_axi_araddr == `UFI_ADDR_IEN1)
        s_axi_rdata <= {24'h00_0000, ien1_reg};
      else if (s_axi_araddr == `UFI_ADDR_IEN2)
        s_axi_rdata <= {24'h00_0000, ien2_reg};
      else if (s_axi_araddr == `UFI_ADDR_IRQ_CTL_A)
        s_axi_rdata <= {30'h0000_0000, ica_reg};
      else if (s_axi_araddr == `UFI_ADDR_EP_INDEX)
        s_axi_rdata <= {29'h0000_0000, epsel_reg};
      else if (s_axi_araddr == `UFI_ADDR_IN_CTL)
        s_axi_rdata <= {24'h00_0000, auto_reg[epsel_reg % NE], 1'b0, tog_reg[epsel_reg % NE],
                        fbt_reg[epsel_reg % NE], 1'b0, under_reg[epsel_reg % NE],
                        occupied[epsel_reg % NE], loaded[epsel_reg % NE]};
      else if (s_axi_araddr == `UFI_ADDR_MAX_PACKET_SIZE)
        s_axi_rdata <= {23'h00_0000, dual[epsel_reg % NE], max_packet_size_reg[epsel_reg % NE]};
      else if (s_axi_araddr == `UFI_ADDR_IN_FIFO || s_axi_araddr == `UFI_ADDR_EVENT)
        s_axi_rdata <= 32'h0000_0000;
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ufi_core

// ### src/ufi_defs.vh
`ifndef UFI_DEFS_VH
`define UFI_DEFS_VH
// register byte offsets
`define UFI_ADDR_STAT1      8'h00
`define UFI_ADDR_STAT2      8'h04
`define UFI_ADDR_IEN1       8'h08
`define UFI_ADDR_IEN2       8'h0C
`define UFI_ADDR_IRQ_CTL_A  8'h10
`define UFI_ADDR_EP_INDEX   8'h14
`define UFI_ADDR_IN_CTL     8'h18
`define UFI_ADDR_MAX_PACKET_SIZE       8'h1C
`define UFI_ADDR_IN_FIFO    8'h20
`define UFI_ADDR_EVENT      8'h24
// status register 2 bit positions
`define UFI_S2_OVR_BIT      4
`define UFI_S2_RST_BIT      5
`define UFI_S2_RES_BIT      6
`define UFI_S2_SUS_BIT      7
// irq control a bits
`define UFI_ICA_FUNC_BIT    0
`define UFI_ICA_SOF_BIT     1
// in control register bits
`define UFI_IC_LOADED_BIT   0
`define UFI_IC_OCC_BIT      1
`define UFI_IC_UNDER_BIT    2
`define UFI_IC_FLUSH_BIT    3
`define UFI_IC_FBT_BIT      4
`define UFI_IC_TOGGLE_BIT   5
`define UFI_IC_AUTO_BIT     7
// timing
`define UFI_CLK_MHZ         250
`define UFI_SUSPEND_US      3000
`define UFI_BUSRESET_NS     2500000
`define UFI_SUSPEND_CYC     (`UFI_SUSPEND_US * `UFI_CLK_MHZ)
`define UFI_BUSRESET_CYC    (`UFI_BUSRESET_NS * `UFI_CLK_MHZ / 1000)
`define UFI_FIFO_BYTES      16
`endif

// ### src/ufi_idle_timer.v
`timescale 1ns/100ps
// counts consecutive cycles of a condition; pulses once on reaching limit
module ufi_idle_timer #(
  parameter LIMIT = 1000
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire cond,
  output reg  hit
);
  reg [31:0] count_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 32'h0000_0000;
      hit       <= 1'b0;
    end else if (!cond) begin
      count_reg <= 32'h0000_0000;
      hit       <= 1'b0;
    end else begin
      hit <= (count_reg == LIMIT - 1);
      if (count_reg != LIMIT)
        count_reg <= count_reg + 32'h0000_0001;
    end
  end
endmodule // ufi_idle_timer

// ### src/ufi_in_fifo.v
`timescale 1ns/100ps
`include "ufi_defs.vh"
// one IN fifo with single/dual packet bookkeeping
module ufi_in_fifo #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         wr_en,
  input  wire [7:0]   wr_data,
  input  wire [AW:0]  max_packet_size,
  input  wire         auto_arm,
  input  wire         arm_set,
  input  wire         pkt_done,
  input  wire         flush,
  input  wire         abort_clr,
  input  wire         rd_en,
  output reg  [7:0]   rd_data,
  output wire         packet_loaded_flag,
  output wire         occupied,
  output wire         dual_mode
);
  reg [7:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0]   wcnt_reg;
  reg [1:0]    npkt_reg;
  wire         release_pkt = pkt_done | flush;
  wire         arm = arm_set | (auto_arm & wr_en & (wcnt_reg + 1'b1 == max_packet_size));
  assign dual_mode = (max_packet_size <= DEPTH / 2);
  // dual mode: loaded flag only while both slots are full, drops as soon as one slot is free
  assign packet_loaded_flag = dual_mode ? (npkt_reg == 2'd2) : (npkt_reg != 2'd0);
  assign occupied = (npkt_reg != 2'd0);
  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wptr_reg] <= wr_data;
    end
    rd_data <= mem[rptr_reg];
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      wcnt_reg <= {(AW+1){1'b0}};
      npkt_reg <= 2'd0;
    end else begin
      if (wr_en)
        wptr_reg <= wptr_reg + 1'b1;
      if (rd_en)
        rptr_reg <= rptr_reg + 1'b1;
      if (arm)
        wcnt_reg <= {(AW+1){1'b0}};
      else if (wr_en)
        wcnt_reg <= wcnt_reg + 1'b1;
      // flush acts as one packet sent: drops the older one
      if (abort_clr)
        npkt_reg <= 2'd0;
      else if (arm && !release_pkt && npkt_reg != 2'd2)
        npkt_reg <= dual_mode ? npkt_reg + 2'd1 : 2'd1;
      else if (!arm && release_pkt && npkt_reg != 2'd0)
        npkt_reg <= npkt_reg - 2'd1;
    end
  end
endmodule // ufi_in_fifo

// ### dv/ufi_checker.sv
`timescale 1ns/100ps
// port-level checks on the function core
module ufi_checker (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire       s_axi_rvalid,
  input wire       ev_sof,
  input wire       in_token,
  input wire [2:0] in_token_ep,
  input wire       in_send,
  input wire       in_nak,
  input wire       sof_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sof_cause; sof_irq |-> $past(ev_sof); endproperty
  a_sof_cause: assert property (p_sof_cause) else $error("frame irq without frame event");
  property p_send_cause; in_send |-> $past(in_token); endproperty
  a_send_cause: assert property (p_send_cause) else $error("packet sent without token");
  property p_nak_cause; in_nak |-> $past(in_token); endproperty
  a_nak_cause: assert property (p_nak_cause) else $error("nak without token");
  // every token to a real endpoint gets exactly one answer next cycle
  sequence s_token; in_token && (in_token_ep <= 3'd4); endsequence
  property p_token_answer; s_token |-> ##1 (in_send || in_nak); endproperty
  a_token_answer: assert property (p_token_answer) else $error("token left unanswered");
  property p_answer_excl; in_send |-> !in_nak; endproperty
  a_answer_excl: assert property (p_answer_excl) else $error("send and nak together");
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
  property p_write_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response late");
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read response late");
  property p_unmapped; s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h24) |=> s_axi_rresp == 2'b10; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

  c_sof: cover property (sof_irq);
  c_send: cover property (in_send);
  c_nak: cover property (in_nak);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // ufi_checker

bind ufi_core ufi_checker u_chk (.*);

// ### dv/ufi_host_model.sv
`timescale 1ns/100ps
// usb engine stand-in: line states, event pulses and in tokens
module ufi_host_model (
  input  wire       aclk,
  output reg        line_idle,
  output reg        line_se0,
  output reg  [2:0] ev_ep,
  output wire       ev_rx_good,
  output wire       ev_tx_ack,
  output wire       ev_tx_sent,
  output wire       ev_halt,
  output wire       ev_overflow,
  output wire       ev_starve,
  output wire       ev_setup_abort,
  output wire       ev_data_last_clr,
  output wire       ev_iso_ovr,
  output wire       ev_sof,
  output reg        in_token,
  output reg  [2:0] in_token_ep
);
  reg [9:0] ev;
  assign {ev_sof, ev_iso_ovr, ev_data_last_clr, ev_setup_abort, ev_starve,
          ev_overflow, ev_halt, ev_tx_sent, ev_tx_ack, ev_rx_good} = ev;
  initial begin
    line_idle = 1'b0;
    line_se0 = 1'b0;
    ev = 10'h000;
    ev_ep = 3'h0;
    in_token = 1'b0;
    in_token_ep = 3'h0;
  end
  // endpoint is inverted once the pulse ends so a stale value is never trusted
  task pulse(input [3:0] k, input [2:0] ep);
    begin
      @(posedge aclk);
      ev <= 10'h001 << k;
      ev_ep <= ep;
      @(posedge aclk);
      ev <= 10'h000;
      ev_ep <= ~ep;
    end
  endtask
  task token(input [2:0] ep);
    begin
      @(posedge aclk);
      in_token <= 1'b1;
      in_token_ep <= ep;
      @(posedge aclk);
      in_token <= 1'b0;
      in_token_ep <= ~ep;
    end
  endtask
  task line(input idle, input se0, input integer n);
    begin
      @(posedge aclk);
      line_idle <= idle;
      line_se0 <= se0;
      repeat (n) @(posedge aclk);
    end
  endtask
endmodule // ufi_host_model

// ### dv/tb_usb_function_irq_in_fifo.sv
`timescale 1ns/100ps
`include "ufi_defs.vh"
module tb_usb_function_irq_in_fifo;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, d1, d2;
  reg  [1:0]  resp;
  wire [3:0]  s_axi_wstrb = 4'h1;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        line_idle, line_se0, ev_rx_good, ev_tx_ack, ev_tx_sent, ev_halt, ev_overflow;
  wire        ev_starve, ev_setup_abort, ev_data_last_clr, ev_iso_ovr, ev_sof, in_token;
  wire [2:0]  ev_ep, in_token_ep;
  wire        in_send, in_nak, in_data_toggle, func_irq, sof_irq;
  integer     n_errors, tests_run, i;
  // event kind, endpoint, expected status 1 and 2
  reg  [3:0]  kd [0:9] = '{0, 3, 4, 1, 5, 0, 6, 7, 3, 8};
  reg  [2:0]  ke [0:9] = '{2, 1, 4, 3, 1, 0, 0, 0, 0, 1};
  reg  [7:0]  e1 [0:9] = '{4, 2, 16, 0, 0, 1, 1, 1, 1, 0};
  reg  [7:0]  e2 [0:9] = '{0, 0, 0, 4, 1, 0, 0, 0, 0, 16};

  // short timers keep suspend and bus reset within a few dozen cycles
  ufi_core #(.SUSPEND_CYC(20), .BUSRESET_CYC(10)) u_dut (.*);
  ufi_host_model u_host (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (s_axi_arready !== 1'b1) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d1 = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      rd(a);
      chk(d1, exp);
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors = n_errors + 1;
    conclude;
  end

  initial begin
    n_errors = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`UFI_ADDR_STAT1, 8'h00);
    rchk(`UFI_ADDR_IEN2, 8'hFF);
    rchk(`UFI_ADDR_MAX_PACKET_SIZE, 12'h008);
    rd(8'h28);
    chk(resp, 2'b10);
    wr(8'h28, 32'h0000_0000);
    chk(resp, 2'b10);
    rchk(`UFI_ADDR_EVENT, 8'h00);
    $display("test reset done");
    // software reads both, then writes back status 1 before status 2
    for (i = 0; i < 10; i = i + 1) begin
      u_host.pulse(kd[i], ke[i]);
      rchk(`UFI_ADDR_STAT1, e1[i]);
      d2 = d1;
      rchk(`UFI_ADDR_STAT2, e2[i]);
      wr(`UFI_ADDR_STAT1, d2);
      wr(`UFI_ADDR_STAT2, d1);
      rchk(`UFI_ADDR_STAT1, 8'h00);
      rchk(`UFI_ADDR_STAT2, 8'h00);
    end
    $display("test flags done");
    wr(`UFI_ADDR_IRQ_CTL_A, 8'h01);
    chk(resp, 2'b00);
    u_host.pulse(4'd0, 3'd2);
    repeat (2) @(posedge aclk);
    #1 chk(func_irq, 1'b1);
    wr(`UFI_ADDR_IEN1, 8'hFB);
    repeat (2) @(posedge aclk);
    #1 chk(func_irq, 1'b0);
    wr(`UFI_ADDR_IEN1, 8'hFF);
    wr(`UFI_ADDR_IRQ_CTL_A, 8'h00);
    repeat (2) @(posedge aclk);
    #1 chk(func_irq, 1'b0);
    wr(`UFI_ADDR_STAT1, 8'h04);
    wr(`UFI_ADDR_IRQ_CTL_A, 8'h02);
    u_host.pulse(4'd9, 3'd0);
    #1 chk(sof_irq, 1'b1);
    wr(`UFI_ADDR_IRQ_CTL_A, 8'h01);
    u_host.pulse(4'd9, 3'd0);
    #1 chk(sof_irq, 1'b0);
    $display("test irq done");
    wr(`UFI_ADDR_IEN2, 8'h7F);
    u_host.line(1'b1, 1'b0, 18);
    u_host.line(1'b0, 1'b0, 2);
    rchk(`UFI_ADDR_STAT2, 8'h00);
    u_host.line(1'b1, 1'b0, 24);
    rchk(`UFI_ADDR_STAT2, 8'h80);
    #1 chk(func_irq, 1'b0);
    wr(`UFI_ADDR_IEN2, 8'hFF);
    repeat (2) @(posedge aclk);
    #1 chk(func_irq, 1'b1);
    wr(`UFI_ADDR_IEN2, 8'h3F);
    u_host.line(1'b0, 1'b0, 2);
    rd(`UFI_ADDR_STAT2);
    chk(d1 & 8'h40, 8'h40);
    #1 chk(func_irq, 1'b1);
    wr(`UFI_ADDR_STAT2, d1);
    rchk(`UFI_ADDR_STAT2, 8'h00);
    $display("test suspend done");
    wr(`UFI_ADDR_IEN1, 8'h00);
    u_host.line(1'b0, 1'b1, 8);
    u_host.line(1'b0, 1'b0, 2);
    rchk(`UFI_ADDR_STAT2, 8'h00);
    u_host.line(1'b0, 1'b1, 14);
    u_host.line(1'b0, 1'b0, 2);
    rchk(`UFI_ADDR_STAT2, 8'h20);
    rchk(`UFI_ADDR_IEN1, 8'hFF);
    wr(`UFI_ADDR_STAT2, 8'h20);
    rchk(`UFI_ADDR_STAT2, 8'h00);
    $display("test bus reset done");
    // upper index bits must be ignored
    wr(`UFI_ADDR_EP_INDEX, 8'h09);
    wr(`UFI_ADDR_MAX_PACKET_SIZE, 8'h08);
    wr(`UFI_ADDR_IN_CTL, 8'h80);
    for (i = 0; i < 8; i = i + 1) wr(`UFI_ADDR_IN_FIFO, i);
    rchk(`UFI_ADDR_IN_CTL, 8'h82);
    for (i = 0; i < 8; i = i + 1) wr(`UFI_ADDR_IN_FIFO, i);
    rchk(`UFI_ADDR_IN_CTL, 8'h83);
    wr(`UFI_ADDR_IN_CTL, 8'h88);
    rchk(`UFI_ADDR_IN_CTL, 8'h82);
    wr(`UFI_ADDR_IN_CTL, 8'h88);
    rchk(`UFI_ADDR_IN_CTL, 8'h80);
    wr(`UFI_ADDR_MAX_PACKET_SIZE, 8'h09);
    rchk(`UFI_ADDR_MAX_PACKET_SIZE, 12'h009);
    wr(`UFI_ADDR_IN_CTL, 8'h00);
    for (i = 0; i < 9; i = i + 1) wr(`UFI_ADDR_IN_FIFO, i);
    wr(`UFI_ADDR_IN_CTL, 8'h01);
    rchk(`UFI_ADDR_IN_CTL, 8'h03);
    u_host.token(3'd1);
    #1 chk(in_send, 1'b1);
    u_host.pulse(4'd1, 3'd1);
    rchk(`UFI_ADDR_IN_CTL, 8'h20);
    u_host.token(3'd3);
    #1 chk(in_nak, 1'b1);
    // control endpoint: single buffered, loaded flag dropped by setup abort
    wr(`UFI_ADDR_EP_INDEX, 8'h00);
    for (i = 0; i < 2; i = i + 1) wr(`UFI_ADDR_IN_FIFO, i);
    wr(`UFI_ADDR_IN_CTL, 8'h01);
    rchk(`UFI_ADDR_IN_CTL, 8'h03);
    u_host.pulse(4'd6, 3'd0);
    rchk(`UFI_ADDR_IN_CTL, 8'h00);
    $display("test fifo done");
    // rate feedback: single-buffer packet size 9, data toggle, flush, no data armed
    wr(`UFI_ADDR_EP_INDEX, 8'h02);
    wr(`UFI_ADDR_MAX_PACKET_SIZE, 8'h09);
    wr(`UFI_ADDR_IN_CTL, 8'h18);
    for (i = 0; i < 3; i = i + 1) begin
      u_host.token(3'd2);
      #1 chk(in_send, 1'b1);
      chk(in_nak, 1'b0);
      chk(in_data_toggle, i[0]);
      u_host.pulse(4'd2, 3'd2);
    end
    $display("test feedback done");
    conclude;
  end
endmodule // tb_usb_function_irq_in_fifo
